// ### dv/sensor_sample_fifo_status_setup_tb_top.sv
// Self-checking bench for the sensor sample FIFO
`timescale 1ns/1ps
`default_nettype none

module sensor_sample_fifo_status_setup_tb_top;
  import ssf_pkg::*;
  logic core_clk_i = 1'b0; // 50 MHz clock
  logic rst_i = 1'b1; // Held for two cycles
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0;
  logic [3:0] wb_sel = 4'h0;
  logic [3:0] sel_q = 4'h1; // Byte enables for the next request
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic strobe;
  logic [47:0] sdata;
  logic fifo_event;
  logic src_start = 1'b0; // Burst request to the sample model
  logic [7:0] src_count = 8'h00;
  logic [3:0] src_gap = 4'h0;
  logic src_busy;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;

  always #10 core_clk_i = ~core_clk_i;

  ssf_sample_fifo ssf_sample_fifo_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(wb_sel),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .sample_strobe_i(strobe), .sample_data_i(sdata),
    .fifo_event_o(fifo_event));

  ssf_sample_source ssf_sample_source_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .start_i(src_start),
    .count_i(src_count), .gap_i(src_gap), .sample_strobe_o(strobe), .sample_data_o(sdata), .busy_o(src_busy));

  ////////////////////////////////////////////////////////////////////////
  // Closing report, shared by the main sequence and the hang guard
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Hang guard; the whole sequence needs well under this many cycles
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Classic single cycle: hold until ack is sampled, then idle one cycle
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge core_clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat <= wd;
    wb_sel <= sel_q;
    // Only the hang guard ends a wait for ack
    do begin
      @(posedge core_clk_i);
    end while (wb_ack !== 1'b1);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge core_clk_i);
    // Ack stands for one cycle only
    chk({31'h0, wb_ack}, 32'h0);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    logic [31:0] unused;
    wb_xfer(1'b1, adr, {24'h0, d}, unused);
  endtask

  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] got;
    wb_xfer(1'b0, adr, 32'h0, got);
    chk(got, exp);
  endtask

  // Fill status, its mirror at zero, and the event output
  task automatic st(input logic [7:0] exp, input logic ev);
    rd(8'h20, {24'h0, exp});
    rd(8'h00, {24'h0, exp});
    chk({31'h0, fifo_event}, {31'h0, ev});
  endtask

  // Retrieve one sample set and compare with sample number s
  task automatic pop(input logic [15:0] s);
    logic [31:0] got;
    rd(8'h80, {~s, s});
    wb_xfer(1'b0, 8'h84, 32'h0, got);
    chk({16'h0, got[15:0]}, {16'h0, s ^ 16'hA5A5});
  endtask

  // Ask the model for a burst and wait, bounded, until it is absorbed
  task automatic push(input logic [7:0] n, input logic [3:0] gap);
    int k;
    k = 0;
    @(posedge core_clk_i);
    src_start <= 1'b1;
    src_count <= n;
    src_gap <= gap;
    @(posedge core_clk_i);
    src_start <= 1'b0;
    @(posedge core_clk_i);
    while (src_busy === 1'b1 && k < 2000) begin
      @(posedge core_clk_i);
      k++;
    end
    repeat (2) @(posedge core_clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence; sample numbers follow the model's running count
  initial begin
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    rd(8'h24, 32'h0);
    st(8'h00, 1'b0);
    wr(8'h20, 8'hFF);
    wr(8'hFC, 8'hFF);
    rd(8'hFC, 32'h0);
    st(8'h00, 1'b0);
    $display("test reset done");
    wr(8'h24, 8'h44);
    push(8'd2, 4'h0);
    st(8'h00, 1'b0);
    wr(8'h88, 8'h02);
    push(8'd3, 4'h0);
    st(8'h03, 1'b0);
    push(8'd1, 4'h2);
    st(8'h44, 1'b1);
    pop(16'd2);
    st(8'h03, 1'b0);
    $display("test watermark done");
    push(8'd30, 4'h0);
    st(8'hE0, 1'b1);
    pop(16'd4);
    st(8'h5F, 1'b1);
    $display("test circular done");
    wr(8'h24, 8'h84);
    rd(8'h24, 32'h44);
    wr(8'h24, 8'h04);
    st(8'h00, 1'b0);
    wr(8'h24, 8'h80);
    push(8'd33, 4'h1);
    st(8'hA0, 1'b1);
    pop(16'd36);
    st(8'h1F, 1'b0);
    $display("test stop done");
    wr(8'h88, 8'h01);
    wr(8'h88, 8'h03);
    st(8'h00, 1'b0);
    rd(8'h88, 32'h3);
    rd(8'h84, 32'h0);
    wr(8'h24, 8'h00);
    wr(8'h24, 8'hC1);
    rd(8'h24, 32'hC1);
    sel_q = 4'hE;
    wr(8'h24, 8'h05);
    sel_q = 4'h1;
    rd(8'h24, 32'hC1);
    push(8'd1, 4'h0);
    st(8'h41, 1'b1);
    pop(16'd69);
    $display("test power and modes done");
    finish_test();
  end
endmodule // sensor_sample_fifo_status_setup_tb_top

`default_nettype wire

// ### dv/ssf_sample_source.sv
// Acquisition-side model that issues numbered sample sets as strobed bursts
`timescale 1ns/1ps
`default_nettype none

module ssf_sample_source (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [7:0] count_i,
  input wire logic [3:0] gap_i,
  output logic sample_strobe_o,
  output logic [47:0] sample_data_o,
  output logic busy_o
);
  logic [7:0] left; // Strobes still to issue
  logic [3:0] wait_cnt; // Idle cycles before the next strobe
  logic [15:0] seq; // Number of the next sample set
  logic [47:0] data_q; // Last sample set issued

  // Data is valid only with the strobe; the inverse shows between strobes so a stale capture is caught
  assign sample_data_o = sample_strobe_o ? data_q : ~data_q;
  assign busy_o = (left != 8'h00) || sample_strobe_o;

  ////////////////////////////////////////////////////////////////////////
  // One strobe per rate period; gap_i idle cycles model a slower rate
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      left <= 8'h00;
      wait_cnt <= 4'h0;
      seq <= 16'h0000;
      data_q <= 48'h0;
      sample_strobe_o <= 1'b0;
    end else begin
      sample_strobe_o <= 1'b0;
      if (start_i) begin
        left <= count_i;
        wait_cnt <= 4'h0;
      end else if (left != 8'h00) begin
        if (wait_cnt == 4'h0) begin
          sample_strobe_o <= 1'b1;
          data_q <= {seq ^ 16'hA5A5, ~seq, seq};
          seq <= seq + 16'h0001;
          left <= left - 8'h01;
          wait_cnt <= gap_i;
        end else begin
          wait_cnt <= wait_cnt - 4'h1;
        end
      end
    end
  end
endmodule // ssf_sample_source

`default_nettype wire

// ### logic/ssf_pkg.sv
// Constants and types shared by the sensor sample FIFO block
package ssf_pkg;

  // FIFO geometry: 32 sample sets of three 16-bit axes
  localparam int SSF_DEPTH = 32;
  localparam int SSF_AXIS_W = 16;
  localparam int SSF_SAMPLE_W = 48;
  localparam logic [5:0] SSF_FULL_COUNT = 6'h20;
  localparam logic [5:0] SSF_EMPTY_COUNT = 6'h00;
  localparam logic [5:0] SSF_WMARK_OFF = 6'h00;

  // Register indices; byte address is four times the index
  localparam logic [5:0] SSF_IDX_STATUS_MIRROR = 6'h00;
  localparam logic [5:0] SSF_IDX_FILL_STATUS = 6'h08;
  localparam logic [5:0] SSF_IDX_CONFIGURATION = 6'h09;
  localparam logic [5:0] SSF_IDX_SAMPLE_XY = 6'h20;
  localparam logic [5:0] SSF_IDX_SAMPLE_Z = 6'h21;
  localparam logic [5:0] SSF_IDX_POWER_CONTROL = 6'h22;

  // Field positions
  localparam int SSF_ADR_IDX_LO = 2;
  localparam int SSF_ADR_IDX_HI = 7;
  localparam int SSF_MODE_LO = 6;
  localparam int SSF_MODE_HI = 7;
  localparam int SSF_WMARK_HI = 5;
  localparam int SSF_POWER_HI = 1;
  localparam int SSF_STOP_BIT = 1;
  localparam int SSF_ACTIVE_BIT = 1;
  localparam int SSF_Z_LO = 32;
  localparam int SSF_BYTE_LANE0 = 0;

  // Reset values
  localparam logic [7:0] SSF_CONFIG_RESET = 8'h00;
  localparam logic [31:0] SSF_RDATA_IDLE = 32'h0000_0000;

  // FIFO operating modes; any code with the upper bit set stops
  typedef enum logic [1:0] {
    SSF_MODE_DISABLED = 2'b00,
    SSF_MODE_CIRCULAR = 2'b01,
    SSF_MODE_STOP = 2'b10,
    SSF_MODE_STOP_ALT = 2'b11
  } ssf_fifo_mode_e;

  // Device power modes; any code with the upper bit set is active
  typedef enum logic [1:0] {
    SSF_PWR_STANDBY = 2'b00,
    SSF_PWR_READY = 2'b01,
    SSF_PWR_ACTIVE = 2'b10,
    SSF_PWR_ACTIVE_ALT = 2'b11
  } ssf_power_e;

endpackage

// ### logic/ssf_sample_fifo.sv
// Sensor sample FIFO with status, status mirror and setup registers
//
// Summary of operation
// R1: Status also readable at address zero
// R2: Entering active mode clears FIFO status
// R3: Push at count 32 sets overflow
// R4: Overflow clears when count below 32
// R5: Watermark flag set when count reaches level
// R6: Watermark flag clears below the level
// R7: Status bits 5:0 give stored count
// R8: One sample pushed per data rate strobe
// R9: Mode 00 off, 01 circular, 1x stop
// R10: Circular full: oldest dropped, newest stored
// R11: Stop full: new samples refused, contents kept
// R12: No direct circular/stop switch while enabled
// R13: Disabling empties FIFO and clears watermark
// R14: Watermark level zero never raises flag
// R15: Watermark never blocks sample storage
// R16: Setup register resets to zero
// R17: Host changes setup only in standby; the code accepts setup writes in any power mode
// R18: Event output is overflow OR watermark
// R19: Reading Z sample pops oldest set
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none

module ssf_sample_fifo
  import ssf_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sample_strobe_i,
  input wire logic [47:0] sample_data_i,
  output logic fifo_event_o
);

  ////////////////////////////////////////////////////////////////////////
  // State

  // Whole block state, registered in one process
  // Storage sits in the struct too; the price is a wide next-state copy each cycle
  typedef struct packed {
    logic [SSF_DEPTH-1:0][SSF_SAMPLE_W-1:0] mem; // Sample storage
    logic [4:0] rd_ptr;            // Oldest sample slot
    logic [4:0] wr_ptr;            // Next free slot
    logic [5:0] count;             // Stored sample count
    logic ovf;                     // Overflow flag
    logic wmk;                     // Watermark flag
    ssf_fifo_mode_e mode;          // Operating mode field
    logic [5:0] wmark;             // Watermark level field
    ssf_power_e power;             // Device power mode
    logic ack;                     // Bus acknowledge
    logic [31:0] dat;              // Registered read data
  } ssf_state_s;

  // All-zero reset also gives disabled mode and standby
  localparam ssf_state_s SSF_STATE_RESET = '0;

  ssf_state_s st;       // Current state
  ssf_state_s next_st;  // Next state

  ////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Mode decode: only code 00 leaves the FIFO off
  function automatic logic ssf_enabled(input ssf_fifo_mode_e m);
    logic on;
    on = 1'b0;
    unique case (m)
      SSF_MODE_DISABLED: on = 1'b0;
      SSF_MODE_CIRCULAR: on = 1'b1;
      SSF_MODE_STOP, SSF_MODE_STOP_ALT: on = 1'b1; // see R9
    endcase
    return on;
  endfunction

  // Upper mode bit alone selects stop behaviour
  function automatic logic ssf_is_stop(input ssf_fifo_mode_e m);
    return m[SSF_STOP_BIT]; // see R9
  endfunction

  // Upper power bit alone marks active mode
  function automatic logic ssf_is_active(input ssf_power_e p);
    return p[SSF_ACTIVE_BIT];
  endfunction

  // Watermark flag level; level zero suppresses it
  function automatic logic ssf_wmk_level(input logic [5:0] cnt,
                                         input logic [5:0] lvl,
                                         input logic on);
    return on && (lvl != SSF_WMARK_OFF) && (cnt >= lvl); // see R5 see R6 see R14
  endfunction

  // Status byte layout: overflow, watermark, count
  function automatic logic [7:0] ssf_status(input ssf_state_s s);
    return {s.ovf, s.wmk, s.count}; // see R7
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Request decode

  logic bus_req;       // New bus cycle not yet answered
  logic [5:0] idx;     // Register index from byte address
  logic cfg_wr;        // Write to setup register
  logic pwr_wr;        // Write to power control register
  logic fifo_on;       // FIFO enabled in current mode
  logic full;          // Count at capacity
  logic pop;           // Host takes oldest sample set
  logic push;          // Acquisition offers a sample set
  logic overrun;       // Sample arrives with no room
  logic circ_drop;     // Circular mode replaces oldest
  logic store;         // Sample is written into storage
  logic [31:0] rdata;  // Read mux output
  ssf_fifo_mode_e wr_mode; // Mode field being written

  // A cycle is taken once; ack blocks a second take
  assign bus_req = wb_cyc_i & wb_stb_i & ~st.ack;
  assign idx = wb_adr_i[SSF_ADR_IDX_HI:SSF_ADR_IDX_LO];
  // Registers are eight bits wide, so only lane 0 writes
  assign cfg_wr = bus_req & wb_we_i & wb_sel_i[SSF_BYTE_LANE0] & (idx == SSF_IDX_CONFIGURATION);
  assign pwr_wr = bus_req & wb_we_i & wb_sel_i[SSF_BYTE_LANE0] & (idx == SSF_IDX_POWER_CONTROL);
  assign wr_mode = ssf_fifo_mode_e'(wb_dat_i[SSF_MODE_HI:SSF_MODE_LO]);
  assign fifo_on = ssf_enabled(st.mode);
  assign full = (st.count == SSF_FULL_COUNT);
  // Reading Z completes a sample set and pops it
  // Limitation: an XY read alone leaves the set in place, so hosts finish with Z
  assign pop = bus_req & ~wb_we_i & (idx == SSF_IDX_SAMPLE_Z) & (st.count != SSF_EMPTY_COUNT); // see R19
  // Samples only arrive while active, one per rate strobe
  assign push = sample_strobe_i & fifo_on & ssf_is_active(st.power); // see R8
  // A pop in the same cycle frees a slot, so that is no overrun
  assign overrun = push & full & ~pop;
  assign circ_drop = overrun & ~ssf_is_stop(st.mode); // see R10
  // Watermark plays no part here; stop mode only refuses when full
  assign store = push & (~full | pop | circ_drop); // see R11 see R15

  ////////////////////////////////////////////////////////////////////////
  // Read mux

  // Read data is registered: one wait state buys a glitch-free data output
  // Unmapped indices read as zero and still get an ack
  always_comb begin
    rdata = SSF_RDATA_IDLE;
    case (idx)
      // Mirror lets the host start draining at address zero
      SSF_IDX_STATUS_MIRROR: rdata = {24'h00_0000, ssf_status(st)}; // see R1
      SSF_IDX_FILL_STATUS: rdata = {24'h00_0000, ssf_status(st)};
      SSF_IDX_CONFIGURATION: rdata = {24'h00_0000, st.mode, st.wmark};
      SSF_IDX_SAMPLE_XY: rdata = st.mem[st.rd_ptr][SSF_Z_LO-1:0];
      SSF_IDX_SAMPLE_Z: rdata = {16'h0000, st.mem[st.rd_ptr][SSF_SAMPLE_W-1:SSF_Z_LO]};
      SSF_IDX_POWER_CONTROL: rdata = {30'h0000_0000, st.power};
      default: rdata = SSF_RDATA_IDLE;
    endcase
    // An empty FIFO shows zero rather than stale sample words
    if ((idx == SSF_IDX_SAMPLE_XY || idx == SSF_IDX_SAMPLE_Z) && st.count == SSF_EMPTY_COUNT) begin
      rdata = SSF_RDATA_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_st = st;
    // Ack is registered: one wait state, then dropped next cycle
    next_st.ack = bus_req;
    if (bus_req && !wb_we_i) begin
      next_st.dat = rdata;
    end
    // Storage write for an accepted or replacing sample
    if (store) begin
      next_st.mem[st.wr_ptr] = sample_data_i; // see R8
      next_st.wr_ptr = st.wr_ptr + 5'h01;
    end
    // Oldest slot moves on a pop or a circular replacement
    if (pop || circ_drop) begin
      next_st.rd_ptr = st.rd_ptr + 5'h01; // see R10 see R19
    end
    // Count moves only when one side acts alone
    if (store && !pop && !circ_drop) begin
      next_st.count = st.count + 6'h01;
    end else if (pop && !store) begin
      next_st.count = st.count - 6'h01; // see R19
    end
    // Set wins: overrun keeps the flag up; only count below 32 drops it
    next_st.ovf = overrun | (st.ovf & (next_st.count == SSF_FULL_COUNT)); // see R3 see R4
    // Setup write; a direct circular/stop switch is refused
    if (cfg_wr) begin
      next_st.wmark = wb_dat_i[SSF_WMARK_HI:0];
      if (!(fifo_on && ssf_enabled(wr_mode) && (ssf_is_stop(wr_mode) != ssf_is_stop(st.mode)))) begin
        next_st.mode = wr_mode; // see R12
      end
    end
    // Power mode is a plain field written by software
    // Leaving active keeps the contents; the next entry, a disabling setup write or reset clears them
    if (pwr_wr) begin
      next_st.power = ssf_power_e'(wb_dat_i[SSF_POWER_HI:0]);
    end
    // A disabled FIFO holds nothing
    if (!ssf_enabled(next_st.mode)) begin
      next_st.count = SSF_EMPTY_COUNT; // see R13
      next_st.rd_ptr = '0;
      next_st.wr_ptr = '0;
      next_st.ovf = 1'b0;
    end
    // Entry to active from standby or ready starts clean
    if (!ssf_is_active(st.power) && ssf_is_active(next_st.power)) begin
      next_st.count = SSF_EMPTY_COUNT; // see R2
      next_st.rd_ptr = '0;
      next_st.wr_ptr = '0;
      next_st.ovf = 1'b0;
    end
    // Flag follows the final count so it never lags a change
    next_st.wmk = ssf_wmk_level(next_st.count, next_st.wmark, ssf_enabled(next_st.mode)); // see R13
    // Synchronous reset; all-zero also clears setup
    if (rst_i) begin
      next_st = SSF_STATE_RESET; // see R16
    end
  end

  // One register for the whole state
  always_ff @(posedge core_clk_i) begin
    st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.dat;
  // Combined event; both flags must fall for it to drop
  assign fifo_event_o = st.ovf | st.wmk; // see R18

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  // All checks sample on the core clock and rest while reset is held;
  // most antecedents exclude setup and power writes, which may legally
  // override a sample or a pop in the same cycle
  default clocking ssf_cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  a_count_bound: assert property (st.count <= SSF_FULL_COUNT) // see R7
    else $error("stored count above capacity");

  // A disabling write in the same cycle empties the FIFO and wins
  a_ovf_set: assert property (push && full && !pop && !cfg_wr |=> st.ovf) // see R3
    else $error("overflow not set on full push");

  a_ovf_clear: assert property (st.count != SSF_FULL_COUNT |-> !st.ovf) // see R4
    else $error("overflow set below capacity");

  a_wmk_level: assert property (st.wmk == (fifo_on && st.wmark != SSF_WMARK_OFF && st.count >= st.wmark)) // see R5
    else $error("watermark flag disagrees with count");

  a_wmk_zero_off: assert property (st.wmark == SSF_WMARK_OFF |-> !st.wmk) // see R14
    else $error("watermark flag with level zero");

  a_disable_empty: assert property (!fifo_on |-> st.count == SSF_EMPTY_COUNT && !st.wmk) // see R13
    else $error("disabled FIFO not empty");

  a_push_count: assert property (push && !full && !pop && !cfg_wr && !pwr_wr // see R8
      |=> st.count == $past(st.count) + 6'h01)
    else $error("accepted sample not counted");

  a_circ_replace: assert property (circ_drop && !cfg_wr && !pwr_wr // see R10
      |=> st.count == SSF_FULL_COUNT && st.rd_ptr == $past(st.rd_ptr) + 5'h01)
    else $error("circular overrun did not replace oldest");

  a_stop_hold: assert property (overrun && ssf_is_stop(st.mode) && !cfg_wr && !pwr_wr // see R11
      |=> $stable(st.wr_ptr) && $stable(st.mem))
    else $error("stop mode stored into full FIFO");

  a_mode_lock: assert property (cfg_wr && fifo_on && ssf_enabled(wr_mode) // see R12
      && ssf_is_stop(wr_mode) != ssf_is_stop(st.mode) |=> $stable(st.mode))
    else $error("direct circular/stop switch taken");

  a_active_clear: assert property (pwr_wr && !ssf_is_active(st.power) && wb_dat_i[SSF_ACTIVE_BIT] // see R2
      |=> st.count == SSF_EMPTY_COUNT && !st.ovf)
    else $error("status not cleared on active entry");

  a_pop_count: assert property (pop && !store && !cfg_wr && !pwr_wr // see R19
      |=> st.count == $past(st.count) - 6'h01 ##1 !wb_ack_o)
    else $error("pop did not decrement count");

  a_event_or: assert property (fifo_event_o == (st.ovf | st.wmk)) // see R18
    else $error("event output not OR of flags");

  a_setup_reset: assert property (@(posedge core_clk_i) $past(rst_i) |-> st.mode == SSF_MODE_DISABLED // see R16
      && st.wmark == SSF_WMARK_OFF)
    else $error("setup not zero after reset");

  // Ack is a one-cycle pulse, so one request can never pop twice
  a_ack_pulse: assert property (wb_ack_o // see R19
      |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  // Mirror read returns the status as it stood when the read was taken
  a_mirror_read: assert property (bus_req && !wb_we_i && idx == SSF_IDX_STATUS_MIRROR // see R1
      |=> wb_dat_o == {24'h00_0000, $past(st.ovf), $past(st.wmk), $past(st.count)})
    else $error("status mirror read differs from status");

  // Fill status read carries overflow, watermark and count in that order
  a_status_read: assert property (bus_req && !wb_we_i && idx == SSF_IDX_FILL_STATUS // see R7
      |=> wb_dat_o == {24'h00_0000, $past(st.ovf), $past(st.wmk), $past(st.count)})
    else $error("fill status read has wrong layout");

  // Count moves only on an accepted sample, a pop or a setup or power write
  a_count_hold: assert property (!push && !pop && !cfg_wr && !pwr_wr // see R8
      |=> $stable(st.count))
    else $error("count changed with no sample or pop");

  // Watermark reached raises the event output in the same cycle
  a_wmk_event: assert property (fifo_on && st.wmark != SSF_WMARK_OFF && st.count >= st.wmark // see R5
      |-> fifo_event_o)
    else $error("watermark reached without event");

  // Below the level the event can only come from overflow
  a_wmk_below: assert property (st.count < st.wmark && !st.ovf // see R6
      |-> !fifo_event_o)
    else $error("event raised below the watermark");

  // Bus outputs leave reset quiet, with no stale event or read data
  a_reset_quiet: assert property ($past(rst_i) // see R16
      |-> !wb_ack_o && !fifo_event_o && wb_dat_o == SSF_RDATA_IDLE)
    else $error("outputs not quiet after reset");

  c_fill_full: cover property (push && st.count == SSF_FULL_COUNT - 6'h01);
  c_circ_over: cover property (circ_drop);
  c_stop_over: cover property (overrun && ssf_is_stop(st.mode));
  c_pop_wmk: cover property (pop && st.wmk ##1 !st.wmk);
  // Refused direct switch between circular and stop
  c_mode_refused: cover property (cfg_wr && fifo_on && ssf_enabled(wr_mode)
      && ssf_is_stop(wr_mode) != ssf_is_stop(st.mode));

endmodule // ssf_sample_fifo

`default_nettype wire
